//--- design/imu_status_and_id_registers.v
// Status/error flags, identification, scratch and flash-count registers of the IMU,
// reached over AHB-Lite. Assumes the sensor datapath, flash engine and self test
// report on hclk, and that the SPI pins and supply comparator arrive asynchronously.
//
// Notes on behaviour
// - Clock error flag bit 7 when sample clock unlocked, only in scaled sync mode.
// - Flash test failure, started by command bit 4, sets flag bit 6.
// - Self test, started by command bit 2, sets flag bit 5 on any sensor failure.
// - Supply below 2.8 V sets bit 4, halts; 250 ms good supply reinitialises.
// - SPI frame whose clock count is not a multiple of 16 sets bit 3.
// - Failed flash update, started by command bit 3, sets flag bit 2.
// - Datapath overrun sets bit 1; reset pin or command bit 7 clears it.
// - Reading the flag register returns its contents, then clears all flags.
// - Flags stay set until read; a persisting condition sets them again.
// - Each gyro axis is a 32-bit twos complement value in high and low words.
// - Gyro high-word scale is 160, 40 or 10 LSB per deg/s by range model.
// - Bias estimation period register is read/write, reset value 0x070A.
// - Firmware revision, date, device number and serial number are read-only.
// - Three freely writable scratch registers.
// - Flash write count is kept as 32 bits, read as lower and upper words.
// - Gyro high word is twos complement, zero rate reads 0x0000, LSB is 1/scale.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "imu_regs_map.vh"

module imu_status_and_id_registers #(
    parameter [31:0] SUPPLY_HOLD_CYCLES = `SUPPLY_HOLD_MS * `CLK_KHZ,
    parameter [1:0]  RANGE_MODEL        = `RANGE_125,
    parameter [15:0] FIRMWARE_REV       = 16'h0100, // Arbitrary value
    parameter [15:0] FIRMWARE_DM        = 16'h0101, // Arbitrary value
    parameter [15:0] FIRMWARE_YEAR      = 16'h2000, // Arbitrary value
    parameter [15:0] DEVICE_NUMBER      = 16'h1234, // Arbitrary value
    parameter [15:0] UNIT_SERIAL        = 16'h0001  // Arbitrary value
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    output wire        irq,
    input  wire        spi_sclk,
    input  wire        spi_cs_n,
    input  wire        supply_low,
    input  wire        sample_clock_unlocked,
    input  wire        flash_test_done,
    input  wire        flash_test_fail,
    input  wire        self_test_done,
    input  wire        self_test_fail,
    input  wire        flash_update_done,
    input  wire        flash_update_fail,
    input  wire        datapath_overrun,
    input  wire        gyro_valid,
    input  wire [31:0] gyro_x,
    input  wire [31:0] gyro_y,
    input  wire [31:0] gyro_z,
    output reg         start_flash_test,
    output reg         start_flash_update,
    output reg         start_self_test,
    output reg         soft_reset,
    output reg         halt_processing,
    output reg         reinit,
    output reg  [7:0]  gyro_scale,
    output reg  [15:0] bias_period
);

    function [15:0] pick_word;
        input [31:0] v;
        input        hi;
        begin
            pick_word = hi ? v[31:16] : v[15:0];
        end
    endfunction

    // Single-cycle slave: never stalls, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    reg        wr_pend_q;
    reg [7:0]  wr_idx_q;
    reg [15:0] flags_q;
    reg [15:0] irq_status_q;
    reg [15:0] irq_mask_q;
    reg [15:0] misc_io_q;
    reg [15:0] scratch_one_q;
    reg [15:0] scratch_two_q;
    reg [15:0] scratch_three_q;
    reg [31:0] flash_writes_q;
    reg [31:0] gyro_x_q;
    reg [31:0] gyro_y_q;
    reg [31:0] gyro_z_q;

    wire       take     = hsel && htrans[1] && hready;
    wire [7:0] a_idx    = haddr[9:2];
    wire       rd_take  = take && !hwrite;
    wire       wr_data  = wr_pend_q && hready;
    wire       flag_rd  = rd_take && (a_idx == `IDX_ERROR_FLAGS);

    // Pin synchronisers; first stages are read only by the second
    reg [2:0] sclk_sync_q;
    reg [2:0] cs_sync_q;
    reg [1:0] supply_sync_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_sync_q   <= 3'h0;
            cs_sync_q     <= 3'h7;
            supply_sync_q <= 2'h0;
        end else begin
            sclk_sync_q   <= {sclk_sync_q[1:0], spi_sclk};
            cs_sync_q     <= {cs_sync_q[1:0], spi_cs_n};
            supply_sync_q <= {supply_sync_q[0], supply_low};
        end
    end
    wire sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];
    wire cs_active = !cs_sync_q[1];
    wire cs_end    = cs_sync_q[1] && !cs_sync_q[2];
    wire low_s     = supply_sync_q[1];

    // SPI frame clock counter; only the residue modulo 16 matters
    reg [3:0] sclk_cnt_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            sclk_cnt_q <= 4'h0;
        else if (cs_end)
            sclk_cnt_q <= 4'h0;
        else if (cs_active && sclk_rise)
            sclk_cnt_q <= sclk_cnt_q + 4'h1;
    end
    wire spi_err = cs_end && ((sclk_cnt_q & `SPI_WORD_MASK) != 4'h0);

    // Supply supervision: halt while low, then hold off for the good-supply period
    reg [31:0] hold_cnt_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt_q      <= 32'h0;
            halt_processing <= 1'b0;
            reinit          <= 1'b0;
        end else begin
            reinit <= 1'b0;
            if (low_s) begin
                halt_processing <= 1'b1;
                hold_cnt_q      <= 32'h0;
            end else if (halt_processing) begin
                if (hold_cnt_q >= SUPPLY_HOLD_CYCLES - 32'h1) begin
                    halt_processing <= 1'b0;
                    reinit          <= 1'b1;
                    hold_cnt_q      <= 32'h0;
                end else begin
                    hold_cnt_q <= hold_cnt_q + 32'h1;
                end
            end
        end
    end

    // Conditions feeding the sticky flags
    wire scaled_mode = misc_io_q[`SYNC_MODE_MSB:`SYNC_MODE_LSB] == `SYNC_MODE_SCALED;
    reg [15:0] events;
    always @* begin
        events = 16'h0000;
        events[`FLAG_CLOCK_ERR]    = sample_clock_unlocked && scaled_mode;
        events[`FLAG_FLASH_TEST]   = flash_test_done && flash_test_fail;
        events[`FLAG_SELF_TEST]    = self_test_done && self_test_fail;
        events[`FLAG_STANDBY]      = low_s;
        events[`FLAG_SPI_ERR]      = spi_err;
        events[`FLAG_FLASH_UPDATE] = flash_update_done && flash_update_fail;
        events[`FLAG_OVERRUN]      = datapath_overrun;
    end

    wire cmd_wr = wr_data && (wr_idx_q == `IDX_GLOBAL_COMMAND);

    // Sticky flags: a new event beats the read clear so nothing is lost
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flags_q <= `RST_ZERO16;
        else if (cmd_wr && hwdata[`CMD_SOFT_RESET])
            flags_q <= events & `FLAG_MASK;
        else if (flag_rd)
            flags_q <= events & `FLAG_MASK;
        else
            flags_q <= (flags_q | events) & `FLAG_MASK;
    end

    // Interrupt status: write one to clear, set wins over clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_status_q <= `RST_ZERO16;
        else if (wr_data && (wr_idx_q == `IDX_IRQ_STATUS))
            irq_status_q <= ((irq_status_q & ~hwdata[15:0]) | events) & `FLAG_MASK;
        else
            irq_status_q <= (irq_status_q | events) & `FLAG_MASK;
    end
    assign irq = |(irq_status_q & irq_mask_q);

    // Global command pulses, one cycle each
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_flash_test   <= 1'b0;
            start_flash_update <= 1'b0;
            start_self_test    <= 1'b0;
            soft_reset         <= 1'b0;
        end else begin
            start_flash_test   <= cmd_wr && hwdata[`CMD_FLASH_TEST];
            start_flash_update <= cmd_wr && hwdata[`CMD_FLASH_UPDATE];
            start_self_test    <= cmd_wr && hwdata[`CMD_SELF_TEST];
            soft_reset         <= cmd_wr && hwdata[`CMD_SOFT_RESET];
        end
    end

    // Writable registers; write data arrives in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q       <= 1'b0;
            wr_idx_q        <= 8'h00;
            bias_period     <= `RST_BIAS_PERIOD;
            misc_io_q       <= `RST_MISC_IO_CONTROL;
            scratch_one_q   <= `RST_ZERO16;
            scratch_two_q   <= `RST_ZERO16;
            scratch_three_q <= `RST_ZERO16;
            irq_mask_q      <= `RST_ZERO16;
        end else begin
            if (hready) begin
                wr_pend_q <= take && hwrite;
                wr_idx_q  <= a_idx;
            end
            if (wr_data) begin
                case (wr_idx_q)
                    `IDX_BIAS_PERIOD:     bias_period     <= hwdata[15:0];
                    `IDX_MISC_IO_CONTROL: misc_io_q       <= hwdata[15:0];
                    `IDX_SCRATCH_ONE:     scratch_one_q   <= hwdata[15:0];
                    `IDX_SCRATCH_TWO:     scratch_two_q   <= hwdata[15:0];
                    `IDX_SCRATCH_THREE:   scratch_three_q <= hwdata[15:0];
                    `IDX_IRQ_MASK:        irq_mask_q      <= hwdata[15:0] & `FLAG_MASK;
                    default: ;
                endcase
            end
        end
    end

    // Flash write cycles counted on every completed update attempt
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flash_writes_q <= 32'h0;
        else if (flash_update_done)
            flash_writes_q <= flash_writes_q + 32'h1;
    end

    // Gyro words captured together so high and low always belong to one sample
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gyro_x_q <= 32'h0;
            gyro_y_q <= 32'h0;
            gyro_z_q <= 32'h0;
        end else if (gyro_valid) begin
            gyro_x_q <= gyro_x;
            gyro_y_q <= gyro_y;
            gyro_z_q <= gyro_z;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            gyro_scale <= 8'h00;
        else if (RANGE_MODEL == `RANGE_125)
            gyro_scale <= `SCALE_125;
        else if (RANGE_MODEL == `RANGE_500)
            gyro_scale <= `SCALE_500;
        else
            gyro_scale <= `SCALE_2000;
    end

    // Read data registered at the address phase, valid in the data phase
    reg [15:0] rd_word;
    always @* begin
        rd_word = 16'h0000;
        case (a_idx)
            `IDX_ERROR_FLAGS:     rd_word = flags_q & `FLAG_MASK;
            `IDX_GYRO_X_LOW:      rd_word = pick_word(gyro_x_q, 1'b0);
            `IDX_GYRO_X_HIGH:     rd_word = pick_word(gyro_x_q, 1'b1);
            `IDX_GYRO_Y_LOW:      rd_word = pick_word(gyro_y_q, 1'b0);
            `IDX_GYRO_Y_HIGH:     rd_word = pick_word(gyro_y_q, 1'b1);
            `IDX_GYRO_Z_LOW:      rd_word = pick_word(gyro_z_q, 1'b0);
            `IDX_GYRO_Z_HIGH:     rd_word = pick_word(gyro_z_q, 1'b1);
            `IDX_MISC_IO_CONTROL: rd_word = misc_io_q;
            `IDX_BIAS_PERIOD:     rd_word = bias_period;
            `IDX_FIRMWARE_REV:    rd_word = FIRMWARE_REV;
            `IDX_FIRMWARE_DM:     rd_word = FIRMWARE_DM;
            `IDX_FIRMWARE_YEAR:   rd_word = FIRMWARE_YEAR;
            `IDX_DEVICE_NUMBER:   rd_word = DEVICE_NUMBER;
            `IDX_UNIT_SERIAL:     rd_word = UNIT_SERIAL;
            `IDX_SCRATCH_ONE:     rd_word = scratch_one_q;
            `IDX_SCRATCH_TWO:     rd_word = scratch_two_q;
            `IDX_SCRATCH_THREE:   rd_word = scratch_three_q;
            `IDX_FLASH_WR_LOWER:  rd_word = pick_word(flash_writes_q, 1'b0);
            `IDX_FLASH_WR_UPPER:  rd_word = pick_word(flash_writes_q, 1'b1);
            `IDX_IRQ_STATUS:      rd_word = irq_status_q;
            `IDX_IRQ_MASK:        rd_word = irq_mask_q;
            default:              rd_word = 16'h0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (rd_take)
            hrdata <= {16'h0000, rd_word};
    end

endmodule // imu_status_and_id_registers

//--- design/imu_regs_map.vh
// Register indices, field positions, reset values and timing for the status/ID bank.
// Assumes byte address = 4 * index, one register per 32-bit word, data in the low 16 bits.
`ifndef IMU_REGS_MAP_VH
`define IMU_REGS_MAP_VH

`define IDX_ERROR_FLAGS      8'h02
`define IDX_GYRO_X_LOW       8'h04
`define IDX_GYRO_X_HIGH      8'h06
`define IDX_GYRO_Y_LOW       8'h08
`define IDX_GYRO_Y_HIGH      8'h0A
`define IDX_GYRO_Z_LOW       8'h0C
`define IDX_GYRO_Z_HIGH      8'h0E
`define IDX_MISC_IO_CONTROL  8'h60
`define IDX_BIAS_PERIOD      8'h66
`define IDX_GLOBAL_COMMAND   8'h68
`define IDX_FIRMWARE_REV     8'h6C
`define IDX_FIRMWARE_DM      8'h6E
`define IDX_FIRMWARE_YEAR    8'h70
`define IDX_DEVICE_NUMBER    8'h72
`define IDX_UNIT_SERIAL      8'h74
`define IDX_SCRATCH_ONE      8'h76
`define IDX_SCRATCH_TWO      8'h78
`define IDX_SCRATCH_THREE    8'h7A
`define IDX_FLASH_WR_LOWER   8'h7C
`define IDX_FLASH_WR_UPPER   8'h7E
`define IDX_IRQ_STATUS       8'h80
`define IDX_IRQ_MASK         8'h81

`define RST_BIAS_PERIOD      16'h070A
`define RST_MISC_IO_CONTROL  16'h00C1
`define RST_ZERO16           16'h0000

`define FLAG_CLOCK_ERR       7
`define FLAG_FLASH_TEST      6
`define FLAG_SELF_TEST       5
`define FLAG_STANDBY         4
`define FLAG_SPI_ERR         3
`define FLAG_FLASH_UPDATE    2
`define FLAG_OVERRUN         1
`define FLAG_MASK            16'h00FE

`define CMD_SOFT_RESET       7
`define CMD_FLASH_TEST       4
`define CMD_FLASH_UPDATE     3
`define CMD_SELF_TEST        2

`define SYNC_MODE_MSB        4
`define SYNC_MODE_LSB        2
`define SYNC_MODE_SCALED     3'h2

`define SCALE_125            8'hA0
`define SCALE_500            8'h28
`define SCALE_2000           8'h0A
`define RANGE_125            2'h0
`define RANGE_500            2'h1

`define SPI_WORD_MASK        4'hF
`define SUPPLY_HOLD_MS       250
`define CLK_KHZ              25000

`endif

//--- verif/imu_regs_properties.sv
// Checker for the status/ID register bank, bound to the design's ports.
// Assumes hready is tied to hreadyout and one AHB-Lite master.
`timescale 1ns/1ps
`include "imu_regs_map.vh"
module imu_regs_properties #(parameter [1:0] RANGE_MODEL = `RANGE_125) (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        supply_low,
    input wire        start_flash_test,
    input wire        start_flash_update,
    input wire        start_self_test,
    input wire        soft_reset,
    input wire        halt_processing,
    input wire        reinit,
    input wire [7:0]  gyro_scale
);
    localparam [7:0] EXP = (RANGE_MODEL == `RANGE_125) ? `SCALE_125 :
                           (RANGE_MODEL == `RANGE_500) ? `SCALE_500 : `SCALE_2000;
    reg       wr_q;
    reg       rd_q;
    reg       up_q;
    reg [7:0] a_q;
    // Track the data phase so checks line up with the write edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            up_q <= 1'b0;
            a_q  <= 8'h00;
        end else begin
            wr_q <= hsel & htrans[1] & hready & hwrite;
            rd_q <= hsel & htrans[1] & hready & ~hwrite;
            up_q <= 1'b1;
            a_q  <= haddr[9:2];
        end
    end
    wire cmd = wr_q && a_q == `IDX_GLOBAL_COMMAND;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_ready_okay: assert property (hreadyout && !hresp) else $error("bad ready or resp");
    chk_rsvd_zero: assert property (rd_q && a_q == `IDX_ERROR_FLAGS |->
        (hrdata & 32'hFFFFFF01) == 32'h0) else $error("reserved flag bits set");
    chk_selftest_go: assert property (cmd && hwdata[2] |-> ##[1:2] start_self_test)
        else $error("self test not started");
    chk_flashtest_go: assert property (cmd && hwdata[4] |-> ##[1:2] start_flash_test)
        else $error("flash test not started");
    chk_update_go: assert property (cmd && hwdata[3] |-> ##[1:2] start_flash_update)
        else $error("flash update not started");
    chk_soft_reset: assert property (cmd && hwdata[7] |-> ##[1:2] soft_reset)
        else $error("soft reset not issued");
    chk_pulse_short: assert property (start_self_test |=> !start_self_test)
        else $error("start pulse too long");
    chk_scale_value: assert property (up_q |-> gyro_scale == EXP)
        else $error("wrong gyro scale");
    chk_halt_entry: assert property ($rose(supply_low) |-> ##[1:5] halt_processing)
        else $error("halt not raised");
    chk_reinit_once: assert property (reinit |=> !reinit && !halt_processing)
        else $error("reinit pulse bad");
    cover property (reinit);
    cover property (start_self_test);
    cover property (rd_q && a_q == `IDX_ERROR_FLAGS && hrdata != 32'h0);
endmodule // imu_regs_properties
bind imu_status_and_id_registers imu_regs_properties #(.RANGE_MODEL(RANGE_MODEL)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .supply_low(supply_low),
    .start_flash_test(start_flash_test), .start_flash_update(start_flash_update),
    .start_self_test(start_self_test), .soft_reset(soft_reset),
    .halt_processing(halt_processing), .reinit(reinit), .gyro_scale(gyro_scale));

//--- verif/spi_host_model.sv
// Serial host model: sends frames of a chosen clock count.
// Assumes the block samples both pins on its own clock; sclk rests low.
`timescale 1ns/1ps
module spi_host_model (
    output reg spi_sclk,
    output reg spi_cs_n
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
    end
    // Clock stands still outside frames, 320 ns period inside
    task frame(input integer n);
        begin
            // Non-blocking so a pin change on an hclk edge is sampled as the old level
            spi_cs_n <= 1'b0;
            #160;
            repeat (n) begin
                spi_sclk <= 1'b1;
                #160;
                spi_sclk <= 1'b0;
                #160;
            end
            spi_cs_n <= 1'b1;
            #640;
        end
    endtask
endmodule // spi_host_model

//--- verif/imu_status_and_id_registers_tb_top.sv
// Self-checking bench for the status/ID register bank.
// Assumes zero-wait AHB-Lite slave and a shortened supply hold count.
`timescale 1ns/1ps
`include "imu_regs_map.vh"
module imu_status_and_id_registers_tb_top;
    localparam [15:0] DEV = 16'h5AA5; // Arbitrary value
    localparam E = `IDX_ERROR_FLAGS;
    localparam [27:0] EVM = {7'h03, 7'h0C, 7'h30, 7'h40};
    localparam [31:0] FLG = {8'h40, 8'h20, 8'h04, 8'h02};
    reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dp_rd = 0, unl = 0, sup = 0, gv = 0;
    reg [31:0] haddr = 0, hwdata = 0, r;
    reg [31:0] g[3];
    reg [1:0]  htrans = 0;
    reg [2:0]  hsize = 0;
    reg [6:0]  ev = 0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, sclk, cs_n, halt, reinit;
    wire [7:0] scale;
    wire [15:0] bias;
    integer err_count = 0, checks = 0, i;
    reg [31:0] q[$];
    initial forever #20 hclk = ~hclk;
    spi_host_model u_host (.spi_sclk(sclk), .spi_cs_n(cs_n));
    imu_status_and_id_registers #(.SUPPLY_HOLD_CYCLES(32'd20), .RANGE_MODEL(`RANGE_500),
        .DEVICE_NUMBER(DEV)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .spi_sclk(sclk), .spi_cs_n(cs_n), .supply_low(sup),
        .sample_clock_unlocked(unl), .flash_test_done(ev[0]), .flash_test_fail(ev[1]),
        .self_test_done(ev[2]), .self_test_fail(ev[3]), .flash_update_done(ev[4]),
        .flash_update_fail(ev[5]), .datapath_overrun(ev[6]), .gyro_valid(gv),
        .gyro_x(g[0]), .gyro_y(g[1]), .gyro_z(g[2]), .start_flash_test(),
        .start_flash_update(), .start_self_test(), .soft_reset(), .halt_processing(halt),
        .reinit(reinit), .gyro_scale(scale), .bias_period(bias));
    task check(input [31:0] s, input [31:0] e);
        begin
            checks = checks + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", checks, err_count);
            if (err_count == 0 && checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    // Entered just after a clock edge; waits on hready, never a fixed count
    task xfer(input [7:0] a, input w, input [31:0] d);
        begin
            hsel <= 1; htrans <= 2'h2; haddr <= {22'h0, a, 2'h0}; hwrite <= w; hsize <= 3'h2;
            @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
            htrans <= 2'h0; hwdata <= d; dp_rd <= !w;
            @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
            dp_rd <= 0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin q.push_back(e); xfer(a, 0, 32'h0); end
    endtask
    // Extra edge keeps two pulses in a row from merging into one long event
    task pulse(input [6:0] m);
        begin ev <= m; @(posedge hclk); ev <= 0; @(posedge hclk); end
    endtask
    // Output chosen by k is looked at on the falling edge, when it has settled
    task ck(input [1:0] k, input [31:0] e);
        begin
            @(negedge hclk);
            case (k)
                2'h0: check({16'h0, bias}, e);
                2'h1: check(halt, e);
                2'h2: check(irq, e);
                default: check(scale, e);
            endcase
            @(posedge hclk);
        end
    endtask
    always @(posedge hclk) if (dp_rd) check(hrdata, q.pop_front());
    initial begin #1000000; err_count = err_count + 1; test_done; end
    initial begin
        r = $urandom(32'h12492527); g[0] = 0; g[1] = 0; g[2] = 0;
        repeat (5) @(posedge hclk); hresetn <= 1; @(posedge hclk);
        rd(E, 0);
        rd(`IDX_BIAS_PERIOD, 32'h070A);
        r = $urandom; xfer(`IDX_DEVICE_NUMBER, 1, r); rd(`IDX_DEVICE_NUMBER, DEV);
        rd(8'h6A, 0);
        for (i = 0; i < 3; i++) begin
            r = $urandom & 32'hFFFF; xfer(8'(`IDX_SCRATCH_ONE + 2 * i), 1, r);
            rd(8'(`IDX_SCRATCH_ONE + 2 * i), r);
        end
        r = $urandom & 32'hFFFF; xfer(`IDX_BIAS_PERIOD, 1, r); rd(`IDX_BIAS_PERIOD, r);
        ck(2'h0, r);
        for (i = 0; i < 4; i++) begin
            pulse(EVM[i*7+:7]); rd(E, FLG[i*8+:8]); rd(E, 0);
        end
        ev <= 7'h40; @(posedge hclk); rd(E, 2); rd(E, 2); ev <= 0; rd(E, 2); rd(E, 0);
        pulse(7'h40); xfer(`IDX_GLOBAL_COMMAND, 1, 32'h80); rd(E, 0);
        // Pin reset in mid-run clears the overrun flag and restores register defaults
        pulse(7'h40); hresetn <= 0; repeat (2) @(posedge hclk); hresetn <= 1; @(posedge hclk);
        rd(E, 0);
        rd(`IDX_BIAS_PERIOD, 32'h070A);
        xfer(`IDX_GLOBAL_COMMAND, 1, 32'h10); xfer(`IDX_GLOBAL_COMMAND, 1, 32'h08);
        xfer(`IDX_GLOBAL_COMMAND, 1, 32'h04);
        unl <= 1; repeat (4) @(posedge hclk); rd(E, 0);
        xfer(`IDX_MISC_IO_CONTROL, 1, 32'hC9); @(posedge hclk); unl <= 0;
        rd(E, 32'h80); rd(E, 0);
        u_host.frame(16); @(posedge hclk); rd(E, 0);
        u_host.frame(15); @(posedge hclk); rd(E, 32'h08); rd(E, 0);
        sup <= 1; repeat (8) @(posedge hclk); ck(2'h1, 1);
        sup <= 0; repeat (10) @(posedge hclk); ck(2'h1, 1);
        for (i = 0; i < 40 && reinit !== 1'b1; i++) @(negedge hclk);
        check(i > 9 && i < 15, 1);
        @(posedge hclk); rd(E, 32'h10); rd(E, 0);
        repeat (3) pulse(7'h10); rd(`IDX_FLASH_WR_LOWER, 3); rd(`IDX_FLASH_WR_UPPER, 0);
        g[0] <= $urandom; g[1] <= $urandom; g[2] <= $urandom; gv <= 1; @(posedge hclk); gv <= 0;
        for (i = 0; i < 3; i++) begin
            rd(8'(`IDX_GYRO_X_LOW + 4 * i), g[i][15:0]);
            rd(8'(`IDX_GYRO_X_HIGH + 4 * i), g[i][31:16]);
        end
        ck(2'h3, 32'h28);
        xfer(`IDX_IRQ_STATUS, 1, 32'hFE); xfer(`IDX_IRQ_MASK, 1, 32'h20); ck(2'h2, 0);
        pulse(7'h0C); ck(2'h2, 1);
        xfer(`IDX_IRQ_MASK, 1, 0); ck(2'h2, 0);
        xfer(`IDX_IRQ_MASK, 1, 32'h20); ck(2'h2, 1);
        xfer(`IDX_IRQ_STATUS, 1, 32'h20); ck(2'h2, 0); rd(`IDX_IRQ_STATUS, 0);
        repeat (2) @(posedge hclk);
        test_done;
    end
endmodule // imu_status_and_id_registers_tb_top
